/* File: ata_task_file_registers.sv */
// Task-file register bank facing the parallel disk host bus
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Sector count zero means 256 sectors
// - Success leaves sector count at zero
// - Failure leaves remaining sectors in count
// - Sector number is start sector or LBA low
// - Cylinder low is LBA bits 15-8
// - Cylinder high is LBA bits 23-16
// - Drive/head layout, resets to A0
// - Mode bit picks CHS or LBA
// - Head bits are LBA 27-24 or head
// - Drive bit picks master or slave
// - Status read clears interrupt, alternate not
// - Status bit layout, resets to 80
// - Error bit set when command failed
// - Device control writable even while busy
// - Soft reset held until bit cleared
// - Interrupt disable bit, cleared at reset
// - Device control layout, resets to 08
// - Feature register write-only command parameter
// - Selects, address and strobes pick registers
// - Drive address returns inverted head, drive
module ata_task_file_registers #(
	parameter bit DRIVE_ID = 1'b0
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Host bus pins
	input  wire logic        command_block_select_n_i,
	input  wire logic        control_block_select_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic        rd_b_i,
	input  wire logic        wr_b_i,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_b_o,
	output logic             intrq_o,
	// Controller core status inputs
	input  wire logic        core_busy_i,
	input  wire logic        core_ready_i,
	input  wire logic        write_fault_flag_i,
	input  wire logic        seek_complete_flag_i,
	input  wire logic        transfer_request_flag_i,
	input  wire logic        corrected_data_flag_i,
	input  wire logic        cmd_done_i,
	input  wire logic        cmd_ok_i,
	input  wire logic [8:0]  sectors_left_i,
	input  wire logic        drq_event_i,
	// Decoded parameters toward the core
	output logic      [7:0]  feature_parameter_o,
	output logic      [8:0]  sector_total_o,
	output logic             lba_mode_o,
	output logic      [27:0] lba_o,
	output logic      [15:0] cylinder_o,
	output logic      [3:0]  head_o,
	output logic      [7:0]  start_sector_o,
	output logic             selected_o,
	output logic             soft_reset_o
);
	logic [7:0] feature_parameter_reg;
	logic [7:0] sector_count_reg;
	logic [7:0] start_sector_or_lba_low_reg;
	logic [7:0] cylinder_low_or_lba_mid_reg;
	logic [7:0] cylinder_high_or_lba_high_reg;
	logic [7:0] drive_head_select_reg;
	logic [7:0] device_control_reg;
	logic       err_reg;
	logic       intrq_reg;
	logic [7:0] data_reg;
	logic       oe_b_reg;
	logic [8:0] total_reg;
	logic [27:0] lba_reg;
	logic [15:0] cyl_reg;
	logic       selected_reg;
	logic       soft_reset_reg;
	logic [7:0] status_now;
	logic [1:0] strb_level;
	logic [1:0] strb_rise;
	logic [4:0] sel_sync;
	logic [4:0] sel_meta;
	logic       cmd_sel;
	logic       ctl_sel;
	logic       rd_evt;
	logic       wr_evt;
	logic       soft_reset_bit;
	logic       tf_wr;
	logic       tf_rd;
	logic [2:0] a;

	// Strobes are active low; sync inverted copies
	strobe_sync #(
		.WIDTH (2)
	) u_strobe (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.async_i ({~rd_b_i, ~wr_b_i}),
		.level_o (strb_level),
		.rise_o  (strb_rise)
	);

	// Selects and address pass two flops before decode
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sel_meta <= 5'h18;
			sel_sync <= 5'h18;
		end else begin
			sel_meta <= {command_block_select_n_i, control_block_select_n_i,
				addr_i};
			sel_sync <= sel_meta;
		end
	end

	assign cmd_sel = !sel_sync[4] && sel_sync[3];
	assign ctl_sel = sel_sync[4] && !sel_sync[3];
	assign a       = sel_sync[2:0];
	assign rd_evt  = strb_rise[1] && !strb_level[0];
	assign wr_evt  = strb_rise[0] && !strb_level[1];
	assign soft_reset_bit  = device_control_reg[task_file_pkg::DC_SRST_BIT];
	// task file strobes; drive selection is gated per register, not for drive/head writes
	assign tf_wr   = wr_evt && cmd_sel && !soft_reset_bit;
	assign tf_rd   = rd_evt && cmd_sel;

	// status layout; busy while in soft reset
	always_comb begin
		status_now = task_file_pkg::ZERO_BYTE;
		status_now[task_file_pkg::ST_BUSY] = core_busy_i || soft_reset_bit;
		status_now[task_file_pkg::ST_RDY]  = core_ready_i && !soft_reset_bit;
		status_now[task_file_pkg::ST_DWF]  = write_fault_flag_i;
		status_now[task_file_pkg::ST_DSC]  = seek_complete_flag_i;
		status_now[task_file_pkg::ST_DRQ]  = transfer_request_flag_i;
		status_now[task_file_pkg::ST_CORRECTED_DATA_FLAG] = corrected_data_flag_i;
		status_now[task_file_pkg::ST_ERR]  = err_reg;
		if (!rst_b_i)
			status_now = task_file_pkg::STATUS_RST;
	end

	// control writes taken even while busy
	// soft reset stays until bit written to zero
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			device_control_reg <= task_file_pkg::CONTROL_RST;
		else if (wr_evt && ctl_sel && a == task_file_pkg::ADDR_CONTROL)
			device_control_reg <= data_i_sync();
	end

	// Data captured at the strobe edge; host holds it through the strobe
	function automatic logic [7:0] data_i_sync();
		return data_i;
	endfunction

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit)
			feature_parameter_reg <= task_file_pkg::ZERO_BYTE;
		else if (tf_wr && selected_reg && a == task_file_pkg::ADDR_FEATURE)
			feature_parameter_reg <= data_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit)
			sector_count_reg <= task_file_pkg::ZERO_BYTE;
		else if (cmd_done_i)
			sector_count_reg <= cmd_ok_i ? task_file_pkg::ZERO_BYTE
				: sectors_left_i[7:0];
		else if (tf_wr && selected_reg && a == task_file_pkg::ADDR_SECT_COUNT)
			sector_count_reg <= data_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit) begin
			start_sector_or_lba_low_reg   <= task_file_pkg::ZERO_BYTE;
			cylinder_low_or_lba_mid_reg   <= task_file_pkg::ZERO_BYTE;
			cylinder_high_or_lba_high_reg <= task_file_pkg::ZERO_BYTE;
		end else if (tf_wr && selected_reg) begin
			if (a == task_file_pkg::ADDR_SECT_NUMBER)
				start_sector_or_lba_low_reg <= data_i;
			if (a == task_file_pkg::ADDR_CYL_LOW)
				cylinder_low_or_lba_mid_reg <= data_i;
			if (a == task_file_pkg::ADDR_CYL_HIGH)
				cylinder_high_or_lba_high_reg <= data_i;
		end
	end

	// fixed ones kept; drive/head written by both drives
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit)
			drive_head_select_reg <= task_file_pkg::DRIVE_HEAD_RST;
		else if (tf_wr && a == task_file_pkg::ADDR_DRIVE_HEAD)
			drive_head_select_reg <= data_i | task_file_pkg::DRIVE_HEAD_RST
				& 8'hA0;
	end

	// error from failed command, cleared on next success
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit)
			err_reg <= 1'b0;
		else if (cmd_done_i)
			err_reg <= !cmd_ok_i;
	end

	// raise when enabled; status read clears
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_reset_bit)
			intrq_reg <= 1'b0;
		else if ((cmd_done_i || drq_event_i) && selected_reg &&
			!device_control_reg[task_file_pkg::DC_NIEN_BIT])
			intrq_reg <= 1'b1;
		else if (tf_rd && selected_reg && a == task_file_pkg::ADDR_STATUS)
			intrq_reg <= 1'b0;
	end

	// Read data: alternate status; drive address
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			data_reg <= task_file_pkg::ZERO_BYTE;
			oe_b_reg <= 1'b1;
		end else if (strb_level[1] && (cmd_sel ? selected_reg : ctl_sel) &&
			(ctl_sel ? a[2:1] == 2'h3 : a != 3'h0 && a != 3'h1)) begin
			oe_b_reg <= 1'b0;
			if (ctl_sel && a == task_file_pkg::ADDR_DRIVE_ADDR)
				data_reg <= {1'b1, 1'b1, ~drive_head_select_reg[3:0],
					~(selected_reg & DRIVE_ID), ~(selected_reg & ~DRIVE_ID)};
			else if (ctl_sel)
				data_reg <= status_now;
			else begin
				unique case (a)
					task_file_pkg::ADDR_SECT_COUNT:
						data_reg <= sector_count_reg;
					task_file_pkg::ADDR_SECT_NUMBER:
						data_reg <= start_sector_or_lba_low_reg;
					task_file_pkg::ADDR_CYL_LOW:
						data_reg <= cylinder_low_or_lba_mid_reg;
					task_file_pkg::ADDR_CYL_HIGH:
						data_reg <= cylinder_high_or_lba_high_reg;
					task_file_pkg::ADDR_DRIVE_HEAD:
						data_reg <= drive_head_select_reg;
					default:
						data_reg <= status_now;
				endcase
			end
		end else begin
			oe_b_reg <= 1'b1;
		end
	end

	// Core-facing decode
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			total_reg      <= task_file_pkg::FULL_SECTORS;
			lba_reg        <= '0;
			cyl_reg        <= '0;
			selected_reg   <= !DRIVE_ID;
			soft_reset_reg <= 1'b0;
		end else begin
			total_reg <= (sector_count_reg == task_file_pkg::ZERO_BYTE) ?
				task_file_pkg::FULL_SECTORS : {1'b0, sector_count_reg};
			lba_reg <= {drive_head_select_reg[3:0],
				cylinder_high_or_lba_high_reg,
				cylinder_low_or_lba_mid_reg, start_sector_or_lba_low_reg};
			cyl_reg <= {cylinder_high_or_lba_high_reg,
				cylinder_low_or_lba_mid_reg};
			selected_reg <= drive_head_select_reg[task_file_pkg::DH_DRIVE_BIT]
				== DRIVE_ID;
			soft_reset_reg <= soft_reset_bit;
		end
	end

	assign data_o              = data_reg;
	assign data_oe_b_o         = oe_b_reg;
	assign intrq_o             = intrq_reg;
	assign feature_parameter_o = feature_parameter_reg;
	assign sector_total_o      = total_reg;
	assign lba_mode_o          = drive_head_select_reg[task_file_pkg::DH_LBA_BIT];
	assign lba_o               = lba_reg;
	assign cylinder_o          = cyl_reg;
	assign head_o              = drive_head_select_reg[3:0];
	assign start_sector_o      = start_sector_or_lba_low_reg;
	assign selected_o          = selected_reg;
	assign soft_reset_o        = soft_reset_reg;

	// Assertions
	// soft reset forces busy
	srst_busy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		soft_reset_bit |-> status_now[task_file_pkg::ST_BUSY])
		else $error("busy not shown in soft reset");
	ok_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cmd_done_i && cmd_ok_i && !soft_reset_bit |=> sector_count_reg == 8'h00)
		else $error("count not zero after success");
	irq_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!intrq_reg && device_control_reg[1] |=> !intrq_reg)
		else $error("interrupt raised while disabled");
	dh_fixed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		drive_head_select_reg[7] && drive_head_select_reg[5])
		else $error("drive/head fixed bits lost");
	count_full_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		sector_count_reg == 8'h00 |=> total_reg == 9'h100)
		else $error("zero count not 256");
	fail_err_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cmd_done_i && !cmd_ok_i && !soft_reset_bit |=> err_reg)
		else $error("error bit not set on failure");
	fail_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cmd_done_i && !cmd_ok_i && !soft_reset_bit |=>
		sector_count_reg == $past(sectors_left_i[7:0]))
		else $error("remaining count wrong");
	srst_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		soft_reset_bit && !(wr_evt && ctl_sel) |=> soft_reset_bit)
		else $error("soft reset dropped by itself");
endmodule
`default_nettype wire

/* File: host_bus_model.sv */
// Host bus model driving the task-file pins
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	// Clock
	input  wire logic       clk_i,
	// Bus pins toward the device
	output logic            cmd_sel_n_o,
	output logic            ctl_sel_n_o,
	output logic [2:0]      addr_o,
	output logic            rd_b_o,
	output logic            wr_b_o,
	output logic [7:0]      wdata_o,
	// Read answer from the device
	input  wire logic [7:0] rdata_i,
	input  wire logic       oe_b_i
);
	// Idle bus at time zero
	initial begin
		cmd_sel_n_o = 1'b1;
		ctl_sel_n_o = 1'b1;
		addr_o = 3'h0;
		rd_b_o = 1'b1;
		wr_b_o = 1'b1;
		wdata_o = 8'h5A;
	end
	task automatic xfer(input logic ctl, input logic [2:0] a, input logic wr,
		input logic [7:0] d, output logic [7:0] q, output logic oe_b);
		@(posedge clk_i);
		#1;
		cmd_sel_n_o = ctl;
		ctl_sel_n_o = !ctl;
		addr_o = a;
		wdata_o = d;
		rd_b_o = wr;
		wr_b_o = !wr;
		// Six clocks low covers the sync delay plus margin
		repeat (6) @(posedge clk_i);
		q = rdata_i;
		oe_b = oe_b_i;
		#1;
		rd_b_o = 1'b1;
		wr_b_o = 1'b1;
		wdata_o = ~d; // Released data never shows the last value
		repeat (5) @(posedge clk_i);
		#1;
		cmd_sel_n_o = 1'b1;
		ctl_sel_n_o = 1'b1;
	endtask
	// bit 3 one, bit 0 zero
	task automatic ctl_wr(input logic srst, input logic nien);
		logic [7:0] q;
		logic       o;
		xfer(1'b1, task_file_pkg::ADDR_CONTROL, 1'b1,
			{4'h0, 1'b1, srst, nien, 1'b0}, q, o);
	endtask
endmodule
`default_nettype wire

/* File: strobe_sync.sv */
// Two-flop synchroniser with rising-edge detect for host strobes
`timescale 1ns/10ps
`default_nettype none
module strobe_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// Async level in, synced level and edge out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	// First flop feeds only the second
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o  = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

/* File: task_file_pkg.sv */
// Constants for the task-file register bank
package task_file_pkg;
	// Register select codes on the three low address lines
	localparam logic [2:0] ADDR_FEATURE     = 3'h1;
	localparam logic [2:0] ADDR_SECT_COUNT  = 3'h2;
	localparam logic [2:0] ADDR_SECT_NUMBER = 3'h3;
	localparam logic [2:0] ADDR_CYL_LOW     = 3'h4;
	localparam logic [2:0] ADDR_CYL_HIGH    = 3'h5;
	localparam logic [2:0] ADDR_DRIVE_HEAD  = 3'h6;
	localparam logic [2:0] ADDR_STATUS      = 3'h7;
	localparam logic [2:0] ADDR_CONTROL     = 3'h6;
	localparam logic [2:0] ADDR_DRIVE_ADDR  = 3'h7;
	// Reset values
	localparam logic [7:0] DRIVE_HEAD_RST   = 8'hA0;
	localparam logic [7:0] STATUS_RST       = 8'h80;
	localparam logic [7:0] CONTROL_RST      = 8'h08;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;
	// Drive/head field positions
	localparam int DH_LBA_BIT   = 6;
	localparam int DH_DRIVE_BIT = 4;
	// Device control field positions
	localparam int DC_SRST_BIT  = 2;
	localparam int DC_NIEN_BIT  = 1;
	// Status bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_RDY  = 6;
	localparam int ST_DWF  = 5;
	localparam int ST_DSC  = 4;
	localparam int ST_DRQ  = 3;
	localparam int ST_CORRECTED_DATA_FLAG = 2;
	localparam int ST_ERR  = 0;
	// Zero count means the full sector count
	localparam logic [8:0] FULL_SECTORS = 9'h100;
endpackage

/* File: test_ata_task_file_registers.sv */
// Self-checking bench for the task-file register bank
`timescale 1ns/10ps
`default_nettype none
module test_ata_task_file_registers;
	logic        clk_i, rst_b_i, cs_n, ctl_n, rd_b, wr_b, oe_b, intrq, oe;
	logic [2:0]  addr;
	logic [7:0]  wdata, rdata, q, feat, ssec, v, dh;
	logic        busy, rdy, write_fault_flag, seek_complete_flag, transfer_request_flag, corrected_data_flag, done, ok, drq_ev;
	logic [8:0]  left, total, n;
	logic        lba_m, sel, srst;
	logic [27:0] lba;
	logic [15:0] cyl;
	logic [3:0]  head;
	logic [31:0] r;
	int          error_cnt, check_count;
	// Host side model and device
	host_bus_model u_host (.clk_i(clk_i), .cmd_sel_n_o(cs_n),
		.ctl_sel_n_o(ctl_n), .addr_o(addr), .rd_b_o(rd_b), .wr_b_o(wr_b),
		.wdata_o(wdata), .rdata_i(rdata), .oe_b_i(oe_b));
	ata_task_file_registers u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.command_block_select_n_i(cs_n), .control_block_select_n_i(ctl_n),
		.addr_i(addr), .rd_b_i(rd_b), .wr_b_i(wr_b), .data_i(wdata),
		.data_o(rdata), .data_oe_b_o(oe_b), .intrq_o(intrq),
		.core_busy_i(busy), .core_ready_i(rdy), .write_fault_flag_i(write_fault_flag),
		.seek_complete_flag_i(seek_complete_flag), .transfer_request_flag_i(transfer_request_flag),
		.corrected_data_flag_i(corrected_data_flag), .cmd_done_i(done), .cmd_ok_i(ok),
		.sectors_left_i(left), .drq_event_i(drq_ev),
		.feature_parameter_o(feat), .sector_total_o(total),
		.lba_mode_o(lba_m), .lba_o(lba), .cylinder_o(cyl), .head_o(head),
		.start_sector_o(ssec), .selected_o(sel), .soft_reset_o(srst));
	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic ctl, input logic [2:0] a);
		u_host.xfer(ctl, a, 1'b0, 8'h00, q, oe);
	endtask
	task automatic wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
		u_host.xfer(ctl, a, 1'b1, d, q, oe);
	endtask
	// Status as the core flags and error say it should read
	function automatic logic [7:0] st_exp(input logic e);
		return {busy, rdy, write_fault_flag, seek_complete_flag, transfer_request_flag, corrected_data_flag, 1'b0, e};
	endfunction
	// One-cycle completion pulse, then time for the request to land
	task automatic finish_cmd(input logic good, input logic [8:0] cnt);
		@(posedge clk_i);
		#1;
		done = 1'b1;
		ok = good;
		left = cnt;
		@(posedge clk_i);
		#1;
		done = 1'b0;
		left = ~cnt;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog sized well above the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		final_report();
	end
	// Main sequence
	initial begin
		void'($urandom(40320));
		{busy, rdy, write_fault_flag, seek_complete_flag, transfer_request_flag, corrected_data_flag, done, ok, drq_ev} = 9'h000;
		left = 9'h000;
		rst_b_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		check({intrq, srst}, 2'b00);
		rd(1'b0, task_file_pkg::ADDR_DRIVE_HEAD);
		check(q, 8'hA0);
		rd(1'b1, task_file_pkg::ADDR_DRIVE_ADDR);
		check(q, 8'hFE);
		// Random task file, first pass with a zero count
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			if (i == 0)
				r[7:0] = 8'h00;
			dh = {1'b1, 1'(i), 2'b10, r[7:4]};
			v = ~r[15:8];
			for (int k = 0; k < 4; k++)
				wr(1'b0, 3'(k + 2), r[k*8 +: 8]);
			wr(1'b0, task_file_pkg::ADDR_DRIVE_HEAD, dh);
			wr(1'b0, task_file_pkg::ADDR_FEATURE, v);
			check(total, (r[7:0] == 8'h00) ? 9'h100 : {1'b0, r[7:0]});
			check(ssec, r[15:8]);
			check(cyl, r[31:16]);
			check(lba_m, dh[6]);
			check(head, dh[3:0]);
			if (dh[6])
				check(lba, {dh[3:0], r[31:8]});
			check(feat, v);
			rd(1'b0, task_file_pkg::ADDR_FEATURE);
			check(oe, 1'b1);
			rd(1'b0, task_file_pkg::ADDR_SECT_COUNT);
			check(q, r[7:0]);
		end
		// Failed command, then a good one
		{busy, rdy, write_fault_flag, seek_complete_flag, transfer_request_flag, corrected_data_flag} = 6'($urandom);
		n = 9'(1 + $urandom_range(254));
		finish_cmd(1'b0, n);
		check(intrq, 1'b1);
		rd(1'b0, task_file_pkg::ADDR_SECT_COUNT);
		check(q, n[7:0]);
		rd(1'b1, task_file_pkg::ADDR_CONTROL);
		check({q, intrq}, {st_exp(1'b1), 1'b1});
		rd(1'b0, task_file_pkg::ADDR_STATUS);
		check({q, intrq}, {st_exp(1'b1), 1'b0});
		// busy low, then a good command
		busy = 1'b0;
		finish_cmd(1'b1, 9'h000);
		rd(1'b0, task_file_pkg::ADDR_SECT_COUNT);
		check(q, 8'h00);
		rd(1'b0, task_file_pkg::ADDR_STATUS);
		check(q, st_exp(1'b0));
		// Masked completion, then an unmasked data request
		u_host.ctl_wr(1'b0, 1'b1);
		finish_cmd(1'b1, 9'h000);
		check(intrq, 1'b0);
		u_host.ctl_wr(1'b0, 1'b0);
		drq_ev = 1'b1;
		@(posedge clk_i);
		#1;
		drq_ev = 1'b0;
		repeat (3) @(posedge clk_i);
		check(intrq, 1'b1);
		rd(1'b0, task_file_pkg::ADDR_STATUS);
		// Soft reset written while busy, held until cleared
		busy = 1'b1;
		u_host.ctl_wr(1'b1, 1'b0);
		// Core idle and ready, so only soft reset can show busy
		busy = 1'b0;
		rdy = 1'b1;
		check(srst, 1'b1);
		rd(1'b1, task_file_pkg::ADDR_CONTROL);
		check(q[7:6], 2'b10);
		rd(1'b0, task_file_pkg::ADDR_DRIVE_HEAD);
		check(q, 8'hA0);
		// Command block writes refused while in soft reset
		wr(1'b0, task_file_pkg::ADDR_FEATURE, 8'h3C);
		check(feat, 8'h00);
		u_host.ctl_wr(1'b0, 1'b0);
		check(srst, 1'b0);
		busy = 1'b0;
		// Other drive selected: command block goes quiet
		// Fixed ones left clear on purpose
		wr(1'b0, task_file_pkg::ADDR_DRIVE_HEAD, 8'h15);
		check(sel, 1'b0);
		rd(1'b0, task_file_pkg::ADDR_SECT_COUNT);
		check(oe, 1'b1);
		rd(1'b1, task_file_pkg::ADDR_DRIVE_ADDR);
		// This device is drive 0 and unselected: both drive bits high
		check(q, {2'b11, ~4'h5, 2'b11});
		wr(1'b0, task_file_pkg::ADDR_DRIVE_HEAD, 8'h00);
		check(sel, 1'b1);
		rd(1'b0, task_file_pkg::ADDR_DRIVE_HEAD);
		check(q, 8'hA0);
		final_report();
	end
endmodule
`default_nettype wire
